// ---- src/adc_ctrl_defines.svh ----
`ifndef ADC_CTRL_DEFINES_SVH
`define ADC_CTRL_DEFINES_SVH

// register indices, byte address is 4x
`define IDX_MAIN 3'h0
`define IDX_SETUP 3'h1
`define IDX_REF 3'h2
`define IDX_TRIG 3'h3
`define IDX_STATUS 3'h4
`define IDX_RESULT 3'h5
`define IDX_LAST 3'h5

`define REG_RESET 8'h00
`define RESULT_RESET 16'h0000

// main control fields
`define ENABLE_BIT 0
`define FLUSH_BIT 1
`define GO_BIT 2
// setup fields
`define RES_LSB 1
`define REP_BIT 3
`define SGN_BIT 4
`define CAP_LSB 5
// reference fields
`define THERM_BIT 0
`define BG_BIT 1
`define REF_LSB 4
// trigger routing fields
`define ACT_LSB 0
`define GRP_LSB 3
// status fields
`define BUSY_BIT 0
`define PEND_BIT 1

// writable masks
`define MAIN_MASK 8'h07
`define SETUP_MASK 8'h7E
`define REF_MASK 8'h73
`define TRIG_MASK 8'h1F

// timing
`define CLK_FREQ_KHZ 200000
`define RATE_LOW_KSPS 225
`define RATE_MED_KSPS 150
`define RATE_HIGH_KSPS 75
`define GAP_LOW_CYC ((`CLK_FREQ_KHZ + `RATE_LOW_KSPS - 1) / `RATE_LOW_KSPS)
`define GAP_MED_CYC ((`CLK_FREQ_KHZ + `RATE_MED_KSPS - 1) / `RATE_MED_KSPS)
`define GAP_HIGH_CYC \
    ((`CLK_FREQ_KHZ + `RATE_HIGH_KSPS - 1) / `RATE_HIGH_KSPS)
`define STEPS_8BIT 3'h3
`define STEPS_12BIT 3'h5

`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

`endif

// ---- src/adc_ctrl_pkg.sv ----
package adc_ctrl_pkg;

    typedef enum logic [1:0]
    {
        RES_12_RIGHT = 2'h0,
        RES_RESERVED = 2'h1,
        RES_8_RIGHT = 2'h2,
        RES_12_LEFT = 2'h3
    } resolution_t;

    typedef enum logic [2:0]
    {
        ACT_NONE = 3'h0,
        ACT_CHAN_ZERO = 3'h1,
        ACT_SYNCHRONISED_RESTART = 3'h6
    } trigger_action_t;

    typedef enum logic [1:0]
    {
        CAP_NONE = 2'h0,
        CAP_LOW = 2'h1,
        CAP_MED = 2'h2,
        CAP_HIGH = 2'h3
    } rate_cap_t;

    typedef enum logic
    {
        SEQ_IDLE = 1'b0,
        SEQ_CONVERT = 1'b1
    } seq_state_t;

    typedef struct packed {
        seq_state_t st;
        logic [8:0] div_cnt;
        logic [2:0] step;
        logic [11:0] gap;
        logic rerun;
    } seq_regs_t;

    typedef struct packed {
        logic aw_ok;
        logic [31:0] waddr;
        logic w_ok;
        logic [7:0] wdata;
        logic wstrb0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } bus_regs_t;

    typedef struct packed {
        logic enable;
        logic go;
        logic flush;
        logic [1:0] rate_cap;
        logic signedness;
        logic auto_repeat;
        logic [1:0] resolution;
        logic [2:0] reference;
        logic bandgap;
        logic thermal;
        logic [1:0] group;
        logic [2:0] action;
        logic [15:0] result;
    } main_regs_t;

endpackage

// ---- src/adc_ctrl_ifs.sv ----
`timescale 1ns/1ps
`default_nettype none

interface conv_seq_if;
    logic enable;
    logic pending;
    logic flush;
    logic eight_bit;
    logic auto_repeat;
    logic [1:0] rate_cap;
    logic start_pulse;
    logic step_pulse;
    logic done_pulse;
    logic busy;
    modport ctrl (output enable, pending, flush, eight_bit, auto_repeat,
        rate_cap, input start_pulse, step_pulse, done_pulse, busy);
    modport seq (input enable, pending, flush, eight_bit, auto_repeat,
        rate_cap, output start_pulse, step_pulse, done_pulse, busy);
endinterface

interface reg_access_if;
    logic wr_en;
    logic [2:0] wr_idx;
    logic [7:0] wr_data;
    logic [2:0] rd_idx;
    logic [31:0] rd_data;
    modport bus (output wr_en, wr_idx, wr_data, rd_idx, input rd_data);
    modport regs (input wr_en, wr_idx, wr_data, rd_idx, output rd_data);
endinterface

`default_nettype wire

// ---- src/axil_reg_port.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_defines.svh"

module axil_reg_port
    import adc_ctrl_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    reg_access_if.bus acc
);

    bus_regs_t s_r;
    bus_regs_t s_nxt;
    logic wr_mapped;
    logic rd_mapped;

    assign wr_mapped = (s_r.waddr[31:5] == 27'h0) &&
        (s_r.waddr[4:2] <= `IDX_LAST);
    assign rd_mapped = (s_axi_araddr[31:5] == 27'h0) &&
        (s_axi_araddr[4:2] <= `IDX_LAST);

    assign s_axi_awready = !s_r.aw_ok && !s_r.bvalid;
    assign s_axi_wready = !s_r.w_ok && !s_r.bvalid;
    assign s_axi_arready = !s_r.rvalid;
    assign s_axi_bvalid = s_r.bvalid;
    assign s_axi_bresp = s_r.bresp;
    assign s_axi_rvalid = s_r.rvalid;
    assign s_axi_rdata = s_r.rdata;
    assign s_axi_rresp = s_r.rresp;

    // only byte lane 0 carries writable register bits
    assign acc.wr_en = s_r.aw_ok && s_r.w_ok && wr_mapped && s_r.wstrb0;
    assign acc.wr_idx = s_r.waddr[4:2];
    assign acc.wr_data = s_r.wdata;
    assign acc.rd_idx = s_axi_araddr[4:2];

    always_comb
    begin
        s_nxt = s_r;
        if (s_axi_awvalid && s_axi_awready)
        begin
            s_nxt.aw_ok = 1'b1;
            s_nxt.waddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            s_nxt.w_ok = 1'b1;
            s_nxt.wdata = s_axi_wdata[7:0];
            s_nxt.wstrb0 = s_axi_wstrb[0];
        end
        if (s_r.aw_ok && s_r.w_ok)
        begin
            s_nxt.aw_ok = 1'b0;
            s_nxt.w_ok = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = wr_mapped ? `RESP_OKAY : `RESP_DECERR;
        end
        if (s_r.bvalid && s_axi_bready)
        begin
            s_nxt.bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready)
        begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata = rd_mapped ? acc.rd_data : 32'h0000_0000;
            s_nxt.rresp = rd_mapped ? `RESP_OKAY : `RESP_DECERR;
        end
        else if (s_r.rvalid && s_axi_rready)
        begin
            s_nxt.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

endmodule

`default_nettype wire

// ---- src/conv_sequencer.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_defines.svh"

module conv_sequencer
    import adc_ctrl_pkg::*;
#(
    parameter int unsigned ADC_DIV = 4
)
(
    input wire logic aclk,
    input wire logic aresetn,
    conv_seq_if.seq cs
);

    localparam logic [8:0] DIV_LAST = 9'(ADC_DIV - 1);
    localparam logic [11:0] GAP_LOW = 12'(`GAP_LOW_CYC - 1);
    localparam logic [11:0] GAP_MED = 12'(`GAP_MED_CYC - 1);
    localparam logic [11:0] GAP_HIGH = 12'(`GAP_HIGH_CYC - 1);

    seq_regs_t s_r;
    seq_regs_t s_nxt;
    logic tick;
    logic [11:0] gap_load;

    // converter clock enable
    assign tick = (s_r.div_cnt == 9'h000);
    assign cs.busy = (s_r.st == SEQ_CONVERT);
    assign cs.step_pulse = tick && (s_r.st == SEQ_CONVERT);

    always_comb
    begin
        case (rate_cap_t'(cs.rate_cap)) // [R7]
            CAP_LOW: gap_load = GAP_LOW;
            CAP_MED: gap_load = GAP_MED;
            CAP_HIGH: gap_load = GAP_HIGH;
            default: gap_load = 12'h000;
        endcase
    end

    always_comb
    begin
        s_nxt = s_r;
        cs.start_pulse = 1'b0;
        cs.done_pulse = 1'b0;
        s_nxt.div_cnt = (s_r.div_cnt == DIV_LAST) ? 9'h000 :
            s_r.div_cnt + 9'h001;
        if (s_r.gap != 12'h000)
        begin
            s_nxt.gap = s_r.gap - 12'h001;
        end
        if (!cs.enable || cs.flush)
        begin
            // abort, restart converter clock next cycle; requests survive a flush, disable clears rerun
            s_nxt.st = SEQ_IDLE; // [R5] [R17]
            s_nxt.div_cnt = 9'h000; // [R5]
            s_nxt.gap = 12'h000;
            if (!cs.enable)
            begin
                s_nxt.rerun = 1'b0; // [R20]
            end
        end
        else
        begin
            case (s_r.st)
                SEQ_IDLE:
                begin
                    if (tick && (cs.pending || s_r.rerun) && // [R6]
                        s_r.gap == 12'h000)
                    begin
                        cs.start_pulse = 1'b1;
                        s_nxt.st = SEQ_CONVERT;
                        s_nxt.step = cs.eight_bit ? `STEPS_8BIT :
                            `STEPS_12BIT; // [R18]
                        s_nxt.rerun = 1'b0;
                        s_nxt.gap = gap_load; // [R7]
                    end
                end
                SEQ_CONVERT:
                begin
                    if (tick)
                    begin
                        if (s_r.step == 3'h0)
                        begin
                            cs.done_pulse = 1'b1;
                            s_nxt.st = SEQ_IDLE;
                            s_nxt.rerun = cs.auto_repeat; // [R9]
                        end
                        else
                        begin
                            s_nxt.step = s_r.step - 3'h1; // [R18]
                        end
                    end
                end
                default:
                begin
                    s_nxt.st = SEQ_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

endmodule

`default_nettype wire

// ---- src/adc_control_event_regs.sv ----
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_defines.svh"

// Notes on behaviour
// [R1] software writes zero to reserved bits
// [R2] bit 0 enables converter
// [R3] go bit self-clears on start
// [R4] go bit acts as channel start
// [R5] flush aborts, restarts converter clock
// [R6] pending requests run after flush
// [R7] rate cap limits sample rate
// [R8] signedness bit selects signed results
// [R9] auto repeat restarts after conversion
// [R10] resolution field sets result format
// [R11] reference field picks source
// [R12] bandgap enable bit
// [R13] thermal sensor enable bit
// [R14] group field picks event channel
// [R15] group values pick channels 0 to 3
// [R16] action: ignore, start, synchronised restart
// [R17] restart flushes, starts next cycle
// [R18] msb then three or five steps
// [R19] signed twelve right pads sign
// [R20] disabled: no starts, no events
// [R21] reset zero, reserved read zero
module adc_control_event_regs
    import adc_ctrl_pkg::*;
#(
    parameter int unsigned ADC_DIV = 4,
    parameter int unsigned EVENT_CHANNELS = 4
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [EVENT_CHANNELS-1:0] event_in,
    input wire logic [11:0] core_code,
    output logic conv_on,
    output logic [2:0] reference_choice,
    output logic bandgap_on,
    output logic thermal_sensor_on,
    output logic signedness_sel,
    output logic sample_strobe,
    output logic bit_step,
    output logic result_ready,
    output logic [15:0] conv_result
);

    main_regs_t s_r;
    main_regs_t s_nxt;
    reg_access_if acc ();
    conv_seq_if cs ();

    logic grp_event;
    logic start_set;
    logic sync_hit;
    logic [15:0] formatted;
    logic [7:0] rd_byte;
    logic [15:0] rd_word;

    axil_reg_port u_bus
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .acc(acc.bus)
    );

    conv_sequencer #(.ADC_DIV(ADC_DIV)) u_seq
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .cs(cs.seq)
    );

    // event channel selected by group starts channel zero
    assign grp_event = event_in[s_r.group]; // [R14] [R15]

    assign sync_hit = s_r.enable && grp_event &&
        (trigger_action_t'(s_r.action) ==
        ACT_SYNCHRONISED_RESTART); // [R16] [R17] [R20]

    always_comb
    begin
        start_set = 1'b0;
        if (s_r.enable) // [R20]
        begin
            if (acc.wr_en && acc.wr_idx == `IDX_MAIN &&
                acc.wr_data[`GO_BIT])
            begin
                start_set = 1'b1; // [R3] [R4]
            end
            if (grp_event && (trigger_action_t'(s_r.action) ==
                ACT_CHAN_ZERO || sync_hit))
            begin
                start_set = 1'b1; // [R16]
            end
        end
    end

    assign cs.enable = s_r.enable; // [R2]
    assign cs.pending = s_r.go;
    assign cs.flush = s_r.flush;
    assign cs.eight_bit = (resolution_t'(s_r.resolution) ==
        RES_8_RIGHT); // [R10]
    assign cs.auto_repeat = s_r.auto_repeat; // [R9]
    assign cs.rate_cap = s_r.rate_cap;

    always_comb
    begin
        case (resolution_t'(s_r.resolution)) // [R10]
            RES_8_RIGHT:
            begin
                formatted = {{8{s_r.signedness & core_code[11]}},
                    core_code[11:4]}; // [R8]
            end
            RES_12_LEFT:
            begin
                formatted = {core_code, 4'h0};
            end
            default:
            begin
                formatted = {{4{s_r.signedness & core_code[11]}},
                    core_code}; // [R19]
            end
        endcase
    end

    always_comb
    begin
        rd_word = 16'h0000;
        rd_byte = 8'h00;
        case (acc.rd_idx)
            `IDX_MAIN:
            begin
                rd_byte[`ENABLE_BIT] = s_r.enable;
                rd_byte[`FLUSH_BIT] = s_r.flush;
                rd_byte[`GO_BIT] = s_r.go;
            end
            `IDX_SETUP:
            begin
                rd_byte[`CAP_LSB +: 2] = s_r.rate_cap;
                rd_byte[`SGN_BIT] = s_r.signedness;
                rd_byte[`REP_BIT] = s_r.auto_repeat;
                rd_byte[`RES_LSB +: 2] = s_r.resolution;
            end
            `IDX_REF:
            begin
                rd_byte[`REF_LSB +: 3] = s_r.reference;
                rd_byte[`BG_BIT] = s_r.bandgap;
                rd_byte[`THERM_BIT] = s_r.thermal;
            end
            `IDX_TRIG:
            begin
                rd_byte[`GRP_LSB +: 2] = s_r.group;
                rd_byte[`ACT_LSB +: 3] = s_r.action;
            end
            `IDX_STATUS:
            begin
                rd_byte[`BUSY_BIT] = cs.busy;
                rd_byte[`PEND_BIT] = s_r.go;
            end
            `IDX_RESULT:
            begin
                rd_word = s_r.result;
            end
            default:
            begin
                rd_byte = 8'h00;
            end
        endcase
    end

    // reserved bits read zero
    assign acc.rd_data = {16'h0000, rd_word | {8'h00, rd_byte}}; // [R21]

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.flush = 1'b0;
        if (acc.wr_en)
        begin
            case (acc.wr_idx)
                `IDX_MAIN:
                begin
                    s_nxt.enable = acc.wr_data[`ENABLE_BIT]; // [R2]
                    s_nxt.flush = acc.wr_data[`FLUSH_BIT]; // [R5]
                end
                `IDX_SETUP:
                begin
                    s_nxt.rate_cap = acc.wr_data[`CAP_LSB +: 2]; // [R7]
                    s_nxt.signedness = acc.wr_data[`SGN_BIT]; // [R8]
                    s_nxt.auto_repeat = acc.wr_data[`REP_BIT]; // [R9]
                    s_nxt.resolution = acc.wr_data[`RES_LSB +: 2];
                end
                `IDX_REF:
                begin
                    s_nxt.reference = acc.wr_data[`REF_LSB +: 3]; // [R11]
                    s_nxt.bandgap = acc.wr_data[`BG_BIT]; // [R12]
                    s_nxt.thermal = acc.wr_data[`THERM_BIT]; // [R13]
                end
                `IDX_TRIG:
                begin
                    s_nxt.group = acc.wr_data[`GRP_LSB +: 2]; // [R14]
                    s_nxt.action = acc.wr_data[`ACT_LSB +: 3]; // [R16]
                end
                default:
                begin
                    s_nxt.enable = s_r.enable;
                end
            endcase
        end
        if (sync_hit)
        begin
            s_nxt.flush = 1'b1; // [R17]
        end
        // set beats clear
        s_nxt.go = (s_r.go & ~cs.start_pulse) | start_set; // [R3]
        if (!s_nxt.enable)
        begin
            s_nxt.go = 1'b0; // [R20]
            s_nxt.flush = 1'b0;
        end
        if (cs.done_pulse)
        begin
            s_nxt.result = formatted;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_r <= '0; // [R21]
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign conv_on = s_r.enable;
    assign reference_choice = s_r.reference; // [R11]
    assign bandgap_on = s_r.bandgap;
    assign thermal_sensor_on = s_r.thermal;
    assign signedness_sel = s_r.signedness;
    assign sample_strobe = cs.start_pulse;
    assign bit_step = cs.step_pulse;
    assign result_ready = cs.done_pulse;
    assign conv_result = s_r.result;

endmodule

`default_nettype wire

// ---- bench/adc_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module adc_core_model
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic sample_strobe,
    input wire logic result_ready,
    input wire logic [11:0] code_in,
    output logic [11:0] core_code
);
    logic busy_r = 1'b0;
    logic [11:0] held_r = 12'h000;
    // code frozen from sample to last tick
    always @(posedge aclk)
        if (!aresetn || result_ready)
            busy_r <= 1'b0;
        else if (sample_strobe)
        begin
            busy_r <= 1'b1;
            held_r <= code_in;
        end
    // invalid outside a conversion
    assign core_code = busy_r ? held_r : ~held_r;
endmodule
`default_nettype wire

// ---- bench/adc_control_event_regs_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module adc_control_event_regs_chk
#(
    parameter int unsigned ADC_DIV = 4
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic conv_on,
    input wire logic signedness_sel,
    input wire logic sample_strobe,
    input wire logic bit_step,
    input wire logic result_ready,
    input wire logic [15:0] conv_result
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence s_signed_done;
        result_ready && signedness_sel;
    endsequence
    sequence s_plain_done;
        result_ready && !signedness_sel;
    endsequence
    a_strobe_needs_on: assert property (sample_strobe |-> conv_on)
        else $error("start while off");
    a_step_needs_on: assert property (bit_step |-> conv_on)
        else $error("tick while off");
    a_strobe_pulse: assert property (sample_strobe |=> !sample_strobe)
        else $error("long start pulse");
    a_ready_delay: assert property (result_ready |->
        $past(sample_strobe, 4 * ADC_DIV) || $past(sample_strobe, 6 * ADC_DIV))
        else $error("bad conversion length");
    a_result_held: assert property (!result_ready |=>
        $stable(conv_result))
        else $error("result changed early");
    a_signed_ext: assert property (s_signed_done |=>
        conv_result[15:11] == 5'h00 || conv_result[15:11] == 5'h1F ||
        conv_result[3:0] == 4'h0)
        else $error("sign not extended");
    a_unsigned_top: assert property (s_plain_done |=>
        conv_result[15:12] == 4'h0 || conv_result[3:0] == 4'h0)
        else $error("unsigned top bits set");
    a_rdata_upper: assert property (
        s_axi_rvalid && s_axi_rresp == 2'h0 |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("read upper half set");
endmodule
bind adc_control_event_regs adc_control_event_regs_chk #(.ADC_DIV(ADC_DIV)) chk
    (.*);
`default_nettype wire

// ---- bench/adc_control_event_regs_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module adc_control_event_regs_tb
    import adc_ctrl_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, v, q;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, rdy_seen = 0;
    logic [1:0] bresp, rresp, rs;
    logic [3:0] wstrb = 4'hF, event_in = 4'h0;
    logic [11:0] code_in = 12'h000, core_code;
    logic conv_on, bandgap_on, thermal_sensor_on, signedness_sel;
    logic sample_strobe, bit_step, result_ready, sg;
    logic [2:0] reference_choice;
    logic [15:0] conv_result;
    logic [15:0] expq[$];
    logic [31:0] seed = 32'h00000026;
    int err_count = 0, num_checks = 0, strb_cnt = 0, i, n;

    always #2.5 aclk = ~aclk;

    adc_control_event_regs #(.ADC_DIV(4), .EVENT_CHANNELS(4)) uut
    (
        .*, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready)
    );
    adc_core_model core (.*);

    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [15:0] fmt(logic [11:0] c, logic [1:0] r,
        logic s);
        if (r == 2'h2)
            return s ? {{8{c[11]}}, c[11:4]} : {8'h00, c[11:4]};
        if (r == 2'h3)
            return {c, 4'h0};
        return s ? {{4{c[11]}}, c} : {4'h0, c};
    endfunction
    task fail(input string m);
        err_count++;
        $display("[FAIL] %0t %s", $time, m);
    endtask
    task finish_test;
        $display("errors %0d checks %0d", err_count, num_checks);
        if (err_count == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task chk_reg(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e)
            fail($sformatf("reg got %h exp %h", g, e));
    endtask
    task chk_res(input logic [15:0] g, input logic [15:0] e);
        num_checks++;
        if (g !== e)
            fail($sformatf("result got %h exp %h", g, e));
    endtask
    task automatic bus(input logic wr, input logic [31:0] a,
        input logic [7:0] d, output logic [31:0] dq, output logic [1:0] rp);
        int k;
        logic aw, w, dn;
        aw = 0;
        w = !wr;
        dn = 0;
        @(posedge aclk);
        if (wr)
        begin
            awaddr <= a;
            wdata <= {24'h000000, d};
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
        end
        else
        begin
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
        end
        for (k = 0; k < 60 && !dn; k++)
        begin
            @(negedge aclk);
            aw |= wr ? awready & awvalid : arready & arvalid;
            w |= wready & wvalid;
            dn = wr ? bvalid : rvalid;
            dq = rdata;
            rp = wr ? bresp : rresp;
            @(posedge aclk);
            if (aw)
                {awvalid, arvalid} <= 2'h0;
            if (w)
                wvalid <= 1'b0;
            if (dn)
                {bready, rready} <= 2'h0;
        end
        if (!dn)
        begin
            fail("bus timeout");
            finish_test();
        end
    endtask
    task wr(input logic [31:0] a, input logic [7:0] d);
        logic [1:0] r;
        bus(1'b1, a, d, q, r);
        chk_reg({30'h0, r}, 32'h0);
    endtask
    task rd_chk(input logic [31:0] a, input logic [31:0] e,
        input logic [1:0] er);
        logic [1:0] r;
        bus(1'b0, a, 8'h00, q, r);
        chk_reg(q, e);
        chk_reg({30'h0, r}, {30'h0, er});
    endtask
    task expect_conv(input logic [1:0] r, input logic s);
        v = rnd();
        code_in <= v[11:0];
        expq.push_back(fmt(v[11:0], r, s));
    endtask
    task wait_res;
        for (n = 0; n < 200 && expq.size() > 0; n++)
            @(posedge aclk);
        if (expq.size() > 0)
        begin
            fail("no result");
            finish_test();
        end
    endtask
    task pulse(input int g);
        @(posedge aclk);
        event_in <= 4'h1 << g;
        @(posedge aclk);
        event_in <= 4'h0;
    endtask
    task quiet(input int g);
        n = strb_cnt;
        pulse(g);
        repeat (30) @(posedge aclk);
        chk_reg(32'(strb_cnt - n), 32'h0);
    endtask

    always @(posedge aclk)
    begin
        rdy_seen <= result_ready;
        if (sample_strobe)
            strb_cnt++;
    end
    always @(negedge aclk)
        if (rdy_seen)
        begin
            if (expq.size() == 0)
                fail("unexpected result");
            else
                chk_res(conv_result, expq.pop_front());
        end

    initial
    begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        for (i = 0; i < 6; i++)
            rd_chk(32'(i * 4), 32'h0, 2'h0);
        rd_chk(32'h18, 32'h0, 2'h3);
        wr(32'h4, 8'hFF);
        rd_chk(32'h4, 32'h7E, 2'h0);
        wr(32'hC, 8'hFF);
        rd_chk(32'hC, 32'h1F, 2'h0);
        for (i = 0; i < 4; i++)
        begin
            v = rnd();
            wr(32'h8, v[7:0]);
            rd_chk(32'h8, v & 32'h73, 2'h0);
            chk_reg({27'h0, reference_choice, bandgap_on, thermal_sensor_on},
                {27'h0, v[6:4], v[1:0]});
        end
        wr(32'h4, 8'h00);
        wr(32'hC, 8'h00);
        quiet(0);
        wr(32'h0, 8'h04);
        repeat (40) @(posedge aclk);
        chk_reg(32'(strb_cnt), 32'h0);
        rd_chk(32'h0, 32'h0, 2'h0);
        wr(32'h0, 8'h01);
        chk_reg({31'h0, conv_on}, 32'h1);
        for (i = 0; i < 6; i++)
        begin
            rs = (i % 3 == 0) ? 2'h0 : (i % 3 == 1) ? 2'h2 : 2'h3;
            sg = i > 2;
            wr(32'h4, {3'h0, sg, 1'b0, rs, 1'b0});
            chk_reg({31'h0, signedness_sel}, {31'h0, sg});
            expect_conv(rs, sg);
            wr(32'h0, 8'h05);
            wait_res();
            rd_chk(32'h0, 32'h1, 2'h0);
        end
        for (i = 0; i < 4; i++)
        begin
            wr(32'hC, {3'h0, i[1:0], (i == 3) ? 3'h6 : 3'h1});
            quiet((i + 1) % 4);
            expect_conv(2'h3, 1'b1);
            pulse(i);
            wait_res();
        end
        wr(32'hC, 8'h00);
        quiet(0);
        expect_conv(2'h3, 1'b1);
        wr(32'h0, 8'h07);
        wait_res();
        wr(32'h0, 8'h00);
        chk_reg({31'h0, conv_on}, 32'h0);
        finish_test();
    end
endmodule
`default_nettype wire
